/* core/adcsq_top.sv */
// converter sequencer: registers, triggers, clock divider, compare, irq
// What this block does
// - start bit high then low starts conversion
// - start bit high holds converter reset, busy
// - busy flag reads one while converting
// - end clears busy, sets request flag, irq
// - power-off bit, resets to one
// - result byte layout follows alignment select
// - channel code routes inputs, sense at six
// - trigger source: start bit or PWM event
// - PWM event: period or duty
// - duty channel select, code three is two
// - delayed start waits count system clocks
// - boundary mode selects compare condition
// - boundary registers follow result alignment
// - clock code divides system clock by power
// - control two upper bits read zero
// - conversion lasts sixteen converter clock periods
module adcsq_top #(
   parameter int unsigned TICKS = adcsq_pkg::CONV_TICKS
) (
   input  wire  logic                 sys_clk,
   input  wire  logic                 srst,
   input  wire  logic [3:0]           avs_address,
   input  wire  logic                 avs_read,
   input  wire  logic                 avs_write,
   input  wire  logic [31:0]          avs_writedata,
   output logic       [31:0]          avs_readdata,
   output logic                       avs_waitrequest,
   input  wire  adcsq_pkg::adcsq_pwm_t pwm_evt,
   input  wire  logic [11:0]          conv_data,
   output logic [8:0]                 conv_route,
   output logic                       conv_power_off,
   output logic                       conv_reset,
   output logic                       conv_sample,
   output logic                       conv_clk_en,
   output logic                       irq
);

   // ------------------------------------------------------------
   // elaboration check
   // ------------------------------------------------------------
   if (TICKS < 2 || TICKS > 64) begin : g_bad_ticks
      $error("TICKS must lie in 2..64");
   end

   // ------------------------------------------------------------
   // functions
   // ------------------------------------------------------------
   // 12-bit value to high/low byte pair per alignment
   function automatic logic [15:0] align_of(input logic a, input logic [11:0] v);
      align_of = a ? {4'h0, v} : {v, 4'h0};
   endfunction

   // byte write into a 12-bit boundary value
   function automatic logic [11:0] put_byte(input logic a, input logic hi,
                                            input logic [11:0] v, input logic [7:0] d);
      if (hi) begin
         put_byte = a ? {d[3:0], v[7:0]} : {d, v[3:0]};
      end else begin
         put_byte = a ? {v[11:8], d} : {v[11:4], d[7:4]};
      end
   endfunction

   // one-hot input route: 0..5 inputs, 6 sense, 7/8 inputs six/seven
   function automatic logic [8:0] route_of(input logic [3:0] c);
      case (c)
         4'h6:    route_of = 9'h100;
         4'h7:    route_of = 9'h040;
         4'h8:    route_of = 9'h080;
         default: route_of = (c < 4'h6) ? 9'(9'h001 << c) : 9'h000;
      endcase
   endfunction

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   adcsq_pkg::adcsq_state_t state;
   adcsq_pkg::adcsq_state_t next_state;
   logic        sw_start;
   logic        power_off;
   logic        align;
   logic [3:0]  chan;
   logic        busy;
   logic [7:0]  ctrl1;
   logic [1:0]  duty_sel;
   logic [7:0]  dly;
   logic [11:0] lo_bound;
   logic [11:0] hi_bound;
   logic [11:0] result;
   logic [1:0]  irq_st;
   logic [1:0]  irq_en;
   logic [7:0]  dly_cnt;
   logic [5:0]  div_cnt;
   logic [5:0]  tick;

   // ------------------------------------------------------------
   // bus decode: answer one cycle after the request appears
   // ------------------------------------------------------------
   wire        req      = avs_read | avs_write;
   wire        first    = req & avs_waitrequest;
   wire        acc_wr   = avs_write & ~avs_waitrequest;
   wire [7:0]  wd       = avs_writedata[7:0];
   wire        wr_c0    = acc_wr && avs_address == adcsq_pkg::A_CTRL0;
   wire        next_sw  = wr_c0 ? wd[adcsq_pkg::C0_START] : sw_start;
   wire [15:0] res_pair = align_of(align, result);
   wire [15:0] lo_pair  = align_of(align, lo_bound);
   wire [15:0] hi_pair  = align_of(align, hi_bound);
   wire        busy_rd  = busy | sw_start;

   // ------------------------------------------------------------
   // trigger selection
   // ------------------------------------------------------------
   wire        trig_pwm = ctrl1[adcsq_pkg::C1_SRC];
   wire        dly_en   = ctrl1[adcsq_pkg::C1_DLY];
   wire        use_duty = ctrl1[adcsq_pkg::C1_PWM_EVENT_SELECT];
   wire [1:0]  mode     = ctrl1[4:3];
   wire [2:0]  ck       = ctrl1[2:0];
   wire [1:0]  duty_ix  = (duty_sel == adcsq_pkg::DUTY_RSVD) ? 2'h2 : duty_sel;
   wire        pwm_hit  = trig_pwm && (use_duty ? pwm_evt.duty[duty_ix] : pwm_evt.period);
   wire [7:0]  eff_dly  = dly_en ? dly : 8'h00;
   wire        cfg_ok   = chan <= adcsq_pkg::CH_LAST && ck != adcsq_pkg::CK_RSVD
                          && !power_off;
   wire        sw_go    = wr_c0 && !wd[adcsq_pkg::C0_START] && sw_start && !trig_pwm;
   wire        idle     = state == adcsq_pkg::S_IDLE;
   wire        hw_now   = idle && pwm_hit && !sw_start && eff_dly == 8'h00;
   wire        dly_go   = state == adcsq_pkg::S_DELAY && dly_cnt == 8'h00;
   wire        start_now = cfg_ok && ((idle && (sw_go || hw_now)) || dly_go);

   // ------------------------------------------------------------
   // converter clock divider: pulse every 2^code system clocks
   // ------------------------------------------------------------
   wire [5:0]  div_mask = 6'((7'h01 << ck) - 7'h01);
   wire        adck_en  = (div_cnt & div_mask) == div_mask;
   wire        in_conv  = state == adcsq_pkg::S_CONV;
   wire        conv_end = in_conv && adck_en && tick == 6'(TICKS - 1);

   // ------------------------------------------------------------
   // window compare of the fresh sample
   // ------------------------------------------------------------
   wire        lo_hit   = conv_data <= lo_bound;
   wire        hi_hit   = conv_data >= hi_bound;
   logic       bnd_hit;
   always_comb begin
      case (mode)
         2'b00:   bnd_hit = !lo_hit && !hi_hit;
         2'b01:   bnd_hit = lo_hit;
         2'b10:   bnd_hit = hi_hit;
         default: bnd_hit = lo_hit || hi_hit;
      endcase
   end

   wire [1:0]  st_set   = {conv_end && bnd_hit, conv_end};
   wire        clr_wr   = acc_wr && avs_address == adcsq_pkg::A_IRQ_CLR;
   // set wins over a clear in the same cycle
   wire [1:0]  next_st  = st_set | (irq_st & ~(clr_wr ? wd[1:0] : 2'b00));

   // ------------------------------------------------------------
   // sequencer next state
   // ------------------------------------------------------------
   always_comb begin
      next_state = state;
      case (state)
         adcsq_pkg::S_IDLE: begin
            if (start_now) begin
               next_state = adcsq_pkg::S_CONV;
            end else if (pwm_hit && !sw_start && cfg_ok) begin
               next_state = adcsq_pkg::S_DELAY;
            end
         end
         adcsq_pkg::S_DELAY: begin
            if (!cfg_ok) begin
               next_state = adcsq_pkg::S_IDLE;
            end else if (dly_go) begin
               next_state = adcsq_pkg::S_CONV;
            end
         end
         adcsq_pkg::S_CONV: begin
            if (conv_end) begin
               next_state = adcsq_pkg::S_IDLE;
            end
         end
         default: next_state = adcsq_pkg::S_IDLE;
      endcase
      if (next_sw) begin
         next_state = adcsq_pkg::S_IDLE;
      end
   end

   // ------------------------------------------------------------
   // read mux
   // ------------------------------------------------------------
   logic [7:0] rd_val;
   always_comb begin
      case (avs_address)
         adcsq_pkg::A_RES_HIGH: rd_val = res_pair[15:8];
         adcsq_pkg::A_RES_LOW:  rd_val = res_pair[7:0];
         adcsq_pkg::A_CTRL0:    rd_val = {sw_start, busy_rd, power_off, align, chan};
         adcsq_pkg::A_CTRL1:    rd_val = ctrl1;
         adcsq_pkg::A_CTRL2:    rd_val = {6'h00, duty_sel};
         adcsq_pkg::A_DELAY:    rd_val = dly;
         adcsq_pkg::A_LOB_HIGH: rd_val = lo_pair[15:8];
         adcsq_pkg::A_LOB_LOW:  rd_val = lo_pair[7:0];
         adcsq_pkg::A_HIB_HIGH: rd_val = hi_pair[15:8];
         adcsq_pkg::A_HIB_LOW:  rd_val = hi_pair[7:0];
         adcsq_pkg::A_IRQ_STAT: rd_val = {6'h00, irq_st};
         adcsq_pkg::A_IRQ_EN:   rd_val = {6'h00, irq_en};
         default:               rd_val = 8'h00;  // unmapped and clear reg read zero
      endcase
   end

   // ------------------------------------------------------------
   // bus handshake
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h0000_0000;
      end else begin
         avs_waitrequest <= ~first;
         if (first) begin
            avs_readdata <= {24'h00_0000, rd_val};
         end
      end
   end

   // ------------------------------------------------------------
   // software registers
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         sw_start  <= adcsq_pkg::CTRL0_RST[adcsq_pkg::C0_START];
         power_off <= adcsq_pkg::CTRL0_RST[adcsq_pkg::C0_OFF];
         align     <= adcsq_pkg::CTRL0_RST[adcsq_pkg::C0_ALIGN];
         chan      <= adcsq_pkg::CTRL0_RST[3:0];
         ctrl1     <= adcsq_pkg::CTRL1_RST;
         duty_sel  <= adcsq_pkg::CTRL2_RST;
         dly       <= adcsq_pkg::DELAY_RST;
         lo_bound  <= 12'h000;
         hi_bound  <= 12'h000;
         irq_en    <= 2'b00;
      end else begin
         sw_start <= next_sw;
         if (wr_c0) begin
            power_off <= wd[adcsq_pkg::C0_OFF];
            align     <= wd[adcsq_pkg::C0_ALIGN];
            chan      <= wd[3:0];
         end
         if (acc_wr) begin
            case (avs_address)
               adcsq_pkg::A_CTRL1:    ctrl1    <= wd;
               adcsq_pkg::A_CTRL2:    duty_sel <= wd[1:0];
               adcsq_pkg::A_DELAY:    dly      <= wd;
               adcsq_pkg::A_LOB_HIGH: lo_bound <= put_byte(align, 1'b1, lo_bound, wd);
               adcsq_pkg::A_LOB_LOW:  lo_bound <= put_byte(align, 1'b0, lo_bound, wd);
               adcsq_pkg::A_HIB_HIGH: hi_bound <= put_byte(align, 1'b1, hi_bound, wd);
               adcsq_pkg::A_HIB_LOW:  hi_bound <= put_byte(align, 1'b0, hi_bound, wd);
               adcsq_pkg::A_IRQ_EN:   irq_en   <= wd[1:0];
               default: ;
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // sequencer, delay counter, divider, conversion ticks
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         state   <= adcsq_pkg::S_IDLE;
         dly_cnt <= 8'h00;
         div_cnt <= 6'h00;
         tick    <= 6'h00;
      end else begin
         state   <= next_state;
         div_cnt <= start_now ? 6'h00 : div_cnt + 6'h01;  // phase restarts per conversion
         if (idle && pwm_hit) begin
            dly_cnt <= eff_dly - 8'h01;
         end else if (dly_cnt != 8'h00) begin
            dly_cnt <= dly_cnt - 8'h01;
         end
         if (start_now || !in_conv) begin
            tick <= 6'h00;
         end else if (adck_en) begin
            tick <= tick + 6'h01;
         end
      end
   end

   // ------------------------------------------------------------
   // busy flag, result capture, interrupt status
   // ------------------------------------------------------------
   // busy resets high: nothing has been converted yet
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         busy   <= adcsq_pkg::CTRL0_RST[adcsq_pkg::C0_BUSY];
         result <= 12'h000;
         irq_st <= 2'b00;
      end else begin
         irq_st <= next_st;
         if (next_sw || start_now) begin
            busy <= 1'b1;
         end else if (conv_end) begin
            busy <= 1'b0;
         end
         if (conv_end) begin
            result <= conv_data;
         end
      end
   end

   // ------------------------------------------------------------
   // converter-facing outputs, all registered
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         conv_route     <= 9'h001;
         conv_power_off <= 1'b1;
         conv_reset     <= 1'b0;
         conv_sample    <= 1'b0;
         conv_clk_en    <= 1'b0;
         irq            <= 1'b0;
      end else begin
         conv_route     <= route_of(chan);
         conv_power_off <= power_off;
         conv_reset     <= next_sw;
         conv_sample    <= start_now;
         conv_clk_en    <= in_conv && adck_en;
         irq            <= |(next_st & irq_en);
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);

   // sixteen converter clocks at divide code zero, one system clock each
   sequence s_conv16;
      in_conv[*8] ##1 in_conv[*7] ##1 conv_end;
   endsequence

   chk_sw_start_go: assert property (sw_go && cfg_ok |=> in_conv && busy)
      else $error("start bit release did not begin a conversion");
   chk_hold_reset: assert property (sw_start[*2] |-> conv_reset && busy_rd && idle)
      else $error("held start bit did not hold reset");
   chk_busy_end: assert property (conv_end && !next_sw |=> !busy && idle)
      else $error("busy not cleared at conversion end");
   chk_eoc_flag: assert property (conv_end |=> irq_st[adcsq_pkg::ST_EOC])
      else $error("end of conversion flag not set");
   chk_irq_level: assert property (irq_st[0] && irq_en[0] && !clr_wr |=> irq)
      else $error("enabled status did not raise irq");
   chk_power_out: assert property ($rose(power_off) |=> conv_power_off && !start_now)
      else $error("power off not reflected");
   chk_align_read: assert property (first && avs_address == adcsq_pkg::A_RES_HIGH && !align
      |=> avs_readdata == {24'h0, $past(result[11:4])})
      else $error("left aligned high byte wrong");
   chk_sense_route: assert property (chan == 4'h6 |=> conv_route == 9'h100)
      else $error("sense input not routed");
   chk_delay_wait: assert property (idle && pwm_hit && cfg_ok && eff_dly == 8'h02 && !next_sw
      && !sw_start |=> !start_now ##1 start_now)
      else $error("delayed start off by a cycle");
   chk_bound_lo: assert property (conv_end && mode == 2'b01 && conv_data <= lo_bound
      |=> irq_st[adcsq_pkg::ST_BND])
      else $error("low boundary hit missed");
   chk_ctrl2_zero: assert property (first && avs_address == adcsq_pkg::A_CTRL2
      |=> avs_readdata[7:2] == 6'h00)
      else $error("control two upper bits not zero");
   chk_conv_len: assert property (disable iff (srst || next_sw)
      start_now && ck == 3'h0 |=> s_conv16)
      else $error("conversion ended early");
   chk_rsvd_block: assert property (conv_sample |-> conv_route != 9'h000
      && !conv_power_off && $past(ck) != adcsq_pkg::CK_RSVD)
      else $error("start with reserved setting");

endmodule

/* core/adcsq_pkg.sv */
// constants, types and register map of the converter sequencer
package adcsq_pkg;

   // ------------------------------------------------------------
   // clocking and conversion timing
   // ------------------------------------------------------------
   localparam int unsigned SYS_CLK_HZ = 40_000_000;
   localparam int unsigned CONV_TICKS = 16;    // converter clock periods per conversion

   // ------------------------------------------------------------
   // register word indices (byte address is four times the index)
   // ------------------------------------------------------------
   localparam logic [3:0] A_RES_HIGH  = 4'h0;
   localparam logic [3:0] A_RES_LOW   = 4'h1;
   localparam logic [3:0] A_CTRL0     = 4'h2;
   localparam logic [3:0] A_CTRL1     = 4'h3;
   localparam logic [3:0] A_CTRL2     = 4'h4;
   localparam logic [3:0] A_DELAY     = 4'h5;
   localparam logic [3:0] A_LOB_HIGH  = 4'h6;
   localparam logic [3:0] A_LOB_LOW   = 4'h7;
   localparam logic [3:0] A_HIB_HIGH  = 4'h8;
   localparam logic [3:0] A_HIB_LOW   = 4'h9;
   localparam logic [3:0] A_IRQ_STAT  = 4'ha;
   localparam logic [3:0] A_IRQ_CLR   = 4'hb;
   localparam logic [3:0] A_IRQ_EN    = 4'hc;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int unsigned C0_START = 7;
   localparam int unsigned C0_BUSY  = 6;
   localparam int unsigned C0_OFF   = 5;
   localparam int unsigned C0_ALIGN = 4;
   localparam int unsigned C1_SRC   = 7;
   localparam int unsigned C1_DLY   = 6;
   localparam int unsigned C1_PWM_EVENT_SELECT  = 5;
   localparam int unsigned ST_EOC   = 0;
   localparam int unsigned ST_BND   = 1;

   // ------------------------------------------------------------
   // reset values and reserved codes
   // ------------------------------------------------------------
   localparam logic [7:0] CTRL0_RST = 8'h60;
   localparam logic [7:0] CTRL1_RST = 8'h00;
   localparam logic [1:0] CTRL2_RST = 2'h0;
   localparam logic [7:0] DELAY_RST = 8'h00;
   localparam logic [3:0] CH_LAST   = 4'h8;
   localparam logic [2:0] CK_RSVD   = 3'h7;
   localparam logic [1:0] DUTY_RSVD = 2'h3;

   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef struct packed {
      logic       period;   // period event pulse
      logic [2:0] duty;     // duty event pulses, one per channel
   } adcsq_pwm_t;

   typedef enum logic [1:0] {S_IDLE, S_DELAY, S_CONV} adcsq_state_t;

endpackage

/* testbench/adcsq_pwm_model.sv */
// partner model: motor PWM event source giving one-cycle event pulses
module adcsq_pwm_model (
   input  wire logic                  sys_clk,
   input  wire logic                  srst,
   input  wire adcsq_pkg::adcsq_pwm_t fire,
   output adcsq_pkg::adcsq_pwm_t      pwm_evt
);
   timeunit 1ns;
   timeprecision 1ps;
   // events leave registered, so they look like the real same-clock interrupt pulses
   always @(posedge sys_clk) begin
      pwm_evt <= srst ? '0 : fire;
   end
endmodule

/* testbench/adcsq_bench.sv */
// self-checking bench of the converter sequencer
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
   $display("Error %s expected %0h seen %0h", nm, e, g); end end
module adcsq_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic                  sys_clk = 1'b0;
   logic                  srst = 1'b1;
   logic [3:0]            avs_address = 4'h0;
   logic                  avs_read = 1'b0;
   logic                  avs_write = 1'b0;
   logic [31:0]           avs_writedata = 32'h0;
   logic [31:0]           avs_readdata;
   logic                  avs_waitrequest;
   adcsq_pkg::adcsq_pwm_t fire = '0;
   adcsq_pkg::adcsq_pwm_t pwm_evt;
   logic [11:0]           conv_data = 12'h000;
   logic [8:0]            conv_route;
   logic                  conv_power_off, conv_reset, conv_sample, conv_clk_en, irq;
   logic [7:0]            q;
   int                    n_errors = 0;
   int                    n_compared = 0;
   int                    cyc = 0, npul = 0, nsamp = 0, gap = 0, lastp = 0, samp = 0, evt = 0;
   always #12.5 sys_clk = ~sys_clk;
   adcsq_top #(.TICKS(16)) dut (.sys_clk(sys_clk), .srst(srst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pwm_evt(pwm_evt),
      .conv_data(conv_data), .conv_route(conv_route), .conv_power_off(conv_power_off),
      .conv_reset(conv_reset), .conv_sample(conv_sample), .conv_clk_en(conv_clk_en), .irq(irq));
   adcsq_pwm_model pwm (.sys_clk(sys_clk), .srst(srst), .fire(fire), .pwm_evt(pwm_evt));
   // --------------------------------------------------------------
   // monitor: pulse counts and spacing, event and sample moments
   // --------------------------------------------------------------
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (conv_clk_en === 1'b1) begin
         npul <= npul + 1;
         gap <= cyc - lastp;
         lastp <= cyc;
      end
      if (conv_sample === 1'b1) begin
         nsamp <= nsamp + 1;
         samp <= cyc;
      end
      if (pwm_evt !== '0) evt <= cyc;
   end
   task automatic results;
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // one avalon transfer; a spare edge after release keeps strobes from toggling twice
   task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
      int n;
      n = 0;
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= {24'h0, d};
      @(posedge sys_clk);
      while (avs_waitrequest !== 1'b0 && n < 50) begin
         @(posedge sys_clk);
         n++;
      end
      if (n >= 50) n_errors++;
      q = avs_readdata[7:0];
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rd(input logic [3:0] a);
      bus(1'b0, a, 8'h00);
   endtask
   // poll the busy flag with a bound rather than assume a duration
   task automatic wait_done;
      int n;
      n = 0;
      q = 8'h40;
      while (q[6] !== 1'b0 && n < 600) begin
         rd(adcsq_pkg::A_CTRL0);
         n++;
      end
      `CHK("busy clear", 1'b0, q[6])
   endtask
   task automatic conv(input logic [7:0] c0);
      wr(adcsq_pkg::A_CTRL0, c0 | 8'h80);
      `CHK("conv reset", 1'b1, conv_reset)
      rd(adcsq_pkg::A_CTRL0);
      `CHK("busy held", 1'b1, q[6])
      wr(adcsq_pkg::A_CTRL0, c0);
      wait_done();
   endtask
   task automatic t_reset;
      rd(adcsq_pkg::A_CTRL0);
      `CHK("ctrl0", 8'h60, q)
      rd(adcsq_pkg::A_CTRL1);
      `CHK("ctrl1", 8'h00, q)
      rd(adcsq_pkg::A_DELAY);
      `CHK("delay", 8'h00, q)
      `CHK("off", 1'b1, conv_power_off)
      wr(adcsq_pkg::A_CTRL2, 8'hff);
      rd(adcsq_pkg::A_CTRL2);
      `CHK("ctrl2", 8'h03, q)
      rd(4'hd);
      `CHK("unmapped", 8'h00, q)
      `CHK("rd upper", 24'h000000, avs_readdata[31:8])
      wr(adcsq_pkg::A_CTRL0, 8'h00);
      @(posedge sys_clk); // power output is registered one edge after the write
      `CHK("on", 1'b0, conv_power_off)
   endtask
   task automatic t_route;
      logic [8:0] e;
      for (int c = 0; c < 16; c++) begin
         wr(adcsq_pkg::A_CTRL0, 8'(c));
         @(posedge sys_clk); // route follows chan one edge later
         e = c < 6 ? 9'(1 << c) : c == 6 ? 9'h100 : c == 7 ? 9'h040 : c == 8 ? 9'h080 : 9'h0;
         `CHK("route", e, conv_route)
      end
   endtask
   // every divide code, alternating alignment; irq enabled then masked
   task automatic t_clock;
      int n0;
      wr(adcsq_pkg::A_IRQ_EN, 8'h01);
      for (int k = 0; k < 7; k++) begin
         wr(adcsq_pkg::A_CTRL1, 8'(k));
         conv_data <= 12'ha5c ^ 12'(k * 291);
         n0 = npul;
         conv({3'b000, 1'(k), 4'h0});
         `CHK("pulses", 16, npul - n0)
         `CHK("gap", 1 << k, gap)
         rd(adcsq_pkg::A_RES_HIGH);
         `CHK("res hi", k[0] ? {4'h0, conv_data[11:8]} : conv_data[11:4], q)
         rd(adcsq_pkg::A_RES_LOW);
         `CHK("res lo", k[0] ? conv_data[7:0] : {conv_data[3:0], 4'h0}, q)
         `CHK("irq", 1'b1, irq)
         wr(adcsq_pkg::A_IRQ_CLR, 8'h03);
         `CHK("irq clr", 1'b0, irq)
      end
      wr(adcsq_pkg::A_IRQ_EN, 8'h00);
      conv(8'h00);
      `CHK("irq masked", 1'b0, irq)
      rd(adcsq_pkg::A_IRQ_STAT);
      `CHK("eoc flag", 1'b1, q[0])
   endtask
   task automatic t_resv(input logic [7:0] c1, input logic [7:0] c0);
      int n0;
      wr(adcsq_pkg::A_CTRL1, c1);
      n0 = nsamp;
      wr(adcsq_pkg::A_CTRL0, c0 | 8'h80);
      wr(adcsq_pkg::A_CTRL0, c0);
      repeat (40) @(posedge sys_clk);
      `CHK("no start", n0, nsamp)
      wr(adcsq_pkg::A_CTRL0, 8'h00); // later scenarios need a valid channel and power
   endtask
   task automatic trig(input logic [7:0] c1, input logic [7:0] dl, input logic [3:0] f,
                       input logic hit);
      int n0;
      wr(adcsq_pkg::A_DELAY, dl);
      wr(adcsq_pkg::A_CTRL1, c1);
      n0 = nsamp;
      fire <= adcsq_pkg::adcsq_pwm_t'(f);
      @(posedge sys_clk);
      fire <= '0;
      repeat (int'(dl) + 6) @(posedge sys_clk);
      `CHK("started", hit, 1'(nsamp != n0))
      if (hit) begin
         `CHK("delay", int'(dl) + 1, samp - evt)
         wait_done();
      end
   endtask
   task automatic t_pwm;
      int ch;
      trig(8'hc0, 8'h05, 4'h8, 1'b1);
      trig(8'hc0, 8'h02, 4'h8, 1'b1);
      trig(8'hc0, 8'hff, 4'h8, 1'b1);
      trig(8'h80, 8'h00, 4'h8, 1'b1);
      trig(8'h00, 8'h00, 4'h8, 1'b0);
      trig(8'ha0, 8'h00, 4'h8, 1'b0);
      for (int c = 0; c < 4; c++) begin
         wr(adcsq_pkg::A_CTRL2, 8'(c));
         ch = c == 3 ? 2 : c;
         trig(8'ha0, 8'h00, 4'(1 << ((ch + 1) % 3)), 1'b0);
         trig(8'ha0, 8'h00, 4'(1 << ch), 1'b1);
      end
   endtask
   // bounds low 0x100 and high 0x800, results on and around both
   task automatic t_bound;
      logic [11:0] vs[5] = '{12'h080, 12'h100, 12'h400, 12'h800, 12'h900};
      logic        e;
      wr(adcsq_pkg::A_CTRL0, 8'h10);
      wr(adcsq_pkg::A_LOB_HIGH, 8'h01);
      wr(adcsq_pkg::A_LOB_LOW, 8'h00);
      wr(adcsq_pkg::A_HIB_HIGH, 8'h08);
      wr(adcsq_pkg::A_HIB_LOW, 8'h00);
      wr(adcsq_pkg::A_CTRL0, 8'h00);
      rd(adcsq_pkg::A_LOB_HIGH);
      `CHK("bound align", 8'h10, q)
      for (int m = 0; m < 4; m++) begin
         for (int i = 0; i < 5; i++) begin
            wr(adcsq_pkg::A_CTRL1, 8'(m << 3));
            conv_data <= vs[i];
            wr(adcsq_pkg::A_IRQ_CLR, 8'h03);
            conv(8'h00);
            e = m == 0 ? (vs[i] > 12'h100 && vs[i] < 12'h800) : 1'b0;
            if (m[0] && vs[i] <= 12'h100) e = 1'b1;
            if (m[1] && vs[i] >= 12'h800) e = 1'b1;
            rd(adcsq_pkg::A_IRQ_STAT);
            `CHK("bound hit", e, q[1])
         end
      end
   endtask
   initial begin
      repeat (6) @(posedge sys_clk);
      srst <= 1'b0;
      @(posedge sys_clk);
      t_reset();
      t_route();
      t_clock();
      t_resv(8'h07, 8'h00);
      t_resv(8'h00, 8'h09);
      t_resv(8'h00, 8'h20);
      t_pwm();
      t_bound();
      results();
   end
   // watchdog well beyond the few thousand cycles the scenarios need
   initial begin
      repeat (60000) @(posedge sys_clk);
      n_errors++;
      results();
   end
endmodule
